// ---- common/emb_pkg.sv ----
`default_nettype none
package emb_pkg;
  // external fetch timing: one fetch slot is three system clocks, nine in fast mode
  localparam int unsigned SLOT_CLOCKS      = 3;
  localparam int unsigned FAST_STRETCH     = 3;    // fast mode: two waits per clock
  // address map boundaries
  localparam logic [15:0] CODE_INT_TOP     = 16'h1fff;
  localparam logic [15:0] SIG_MAKER_TOP    = 16'h007f;
  localparam logic [15:0] SIG_USER_BASE    = 16'h0100;
  localparam logic [15:0] SIG_USER_TOP     = 16'h01ff;
  localparam logic [15:0] FLASH_DATA_TOP   = 16'h00ff;
  localparam logic [7:0]  BITADDR_BASE     = 8'h20;
  localparam logic [7:0]  IO_SPACE_BASE    = 8'h80;
  // control bit positions
  localparam int unsigned STATUS_BANK_LO   = 3;
  localparam int unsigned STATUS_BANK_HI   = 4;
  localparam int unsigned AUX_FORCE_EXT    = 1;
  localparam int unsigned MEMCTL_FLASH_EN  = 3;
  localparam int unsigned MEMCTL_PROG_SEL  = 7;
  // reset values
  localparam logic [7:0]  PORT_RESET       = 8'hff;

  // access kinds requested by the core
  typedef enum logic [2:0] {
    EMB_ACC_FETCH  = 3'b000,
    EMB_ACC_CTAB   = 3'b001,
    EMB_ACC_XPTR   = 3'b010,
    EMB_ACC_XREG   = 3'b011,
    EMB_ACC_DIRECT = 3'b100,
    EMB_ACC_INDIR  = 3'b101,
    EMB_ACC_REG    = 3'b110,
    EMB_ACC_BIT    = 3'b111
  } emb_acc_t;

  // decoded destination
  typedef enum logic [2:0] {
    EMB_TGT_EXT    = 3'b000,
    EMB_TGT_CODE   = 3'b001,
    EMB_TGT_SIG    = 3'b010,
    EMB_TGT_RAM    = 3'b011,
    EMB_TGT_IO     = 3'b100,
    EMB_TGT_FLASH  = 3'b101,
    EMB_TGT_NONE   = 3'b110
  } emb_tgt_t;

  // external bus sequencer
  typedef enum logic [1:0] {
    EMB_ST_IDLE    = 2'b00,
    EMB_ST_ADDR    = 2'b01,
    EMB_ST_STROBE  = 2'b10,
    EMB_ST_DATA    = 2'b11
  } emb_state_t;
endpackage
`default_nettype wire

// ---- rtl/emb_space_decode.sv ----
`default_nettype none
module emb_space_decode (
  // request
  input  wire logic               [2:0]  acc_kind,
  input  wire logic               [15:0] acc_addr,
  input  wire logic               [7:0]  acc_reg_num,
  input  wire logic                      acc_write,
  // configuration
  input  wire logic                      signature_enable,
  input  wire logic                      in_app_prog_select,
  input  wire logic                      force_external_ram,
  input  wire logic                      flash_data_enable,
  input  wire logic                      security_active,
  input  wire logic                      programmer_access,
  input  wire logic                      bank_select_lo,
  input  wire logic                      bank_select_hi,
  // result
  output logic                    [2:0]  tgt,
  output logic                    [15:0] tgt_addr,
  output logic                           tgt_write_ok
);
  logic [7:0] bit_byte;

  // true for code addresses past the internal flash
  function automatic logic above_int_code(input logic [15:0] addr);
    return addr > emb_pkg::CODE_INT_TOP;
  endfunction

  // bit address to carrier byte, register to banked RAM, space choice
  always_comb begin
    tgt          = emb_pkg::EMB_TGT_NONE;
    tgt_addr     = acc_addr;
    tgt_write_ok = acc_write;
    bit_byte     = emb_pkg::BITADDR_BASE + {4'h0, acc_addr[6:3]};
    case (emb_pkg::emb_acc_t'(acc_kind))
      emb_pkg::EMB_ACC_FETCH: begin
        tgt = above_int_code(acc_addr) ? emb_pkg::EMB_TGT_EXT
                                       : emb_pkg::EMB_TGT_CODE;
      end
      emb_pkg::EMB_ACC_CTAB: begin
        if (signature_enable) begin
          // never reaches code memory or the external bus
          if (acc_addr <= emb_pkg::SIG_MAKER_TOP ||
              (acc_addr >= emb_pkg::SIG_USER_BASE && acc_addr <= emb_pkg::SIG_USER_TOP)) begin
            tgt = emb_pkg::EMB_TGT_SIG;
          end else begin
            tgt = emb_pkg::EMB_TGT_NONE;
          end
        end else begin
          tgt = above_int_code(acc_addr) ? emb_pkg::EMB_TGT_EXT
                                         : emb_pkg::EMB_TGT_CODE;
        end
      end
      emb_pkg::EMB_ACC_XPTR: begin
        if (force_external_ram) begin
          tgt = emb_pkg::EMB_TGT_EXT;
        end else if (in_app_prog_select && signature_enable) begin
          tgt          = emb_pkg::EMB_TGT_SIG;
          tgt_addr     = emb_pkg::SIG_USER_BASE | {8'h00, acc_addr[7:0]};
          tgt_write_ok = acc_write && (!security_active || programmer_access);
        end else if (!in_app_prog_select && flash_data_enable &&
                     acc_addr <= emb_pkg::FLASH_DATA_TOP) begin
          tgt = emb_pkg::EMB_TGT_FLASH;
        end else begin
          tgt = emb_pkg::EMB_TGT_EXT;
        end
      end
      emb_pkg::EMB_ACC_XREG: begin
        tgt      = emb_pkg::EMB_TGT_EXT;
        tgt_addr = {8'h00, acc_addr[7:0]};
      end
      emb_pkg::EMB_ACC_DIRECT: begin
        tgt      = (acc_addr[7:0] >= emb_pkg::IO_SPACE_BASE) ? emb_pkg::EMB_TGT_IO
                                                             : emb_pkg::EMB_TGT_RAM;
        tgt_addr = {8'h00, acc_addr[7:0]};
      end
      emb_pkg::EMB_ACC_INDIR: begin
        tgt      = emb_pkg::EMB_TGT_RAM;
        tgt_addr = {8'h00, acc_addr[7:0]};
      end
      emb_pkg::EMB_ACC_REG: begin
        tgt      = emb_pkg::EMB_TGT_RAM;
        tgt_addr = {11'h000, bank_select_hi, bank_select_lo, acc_reg_num[2:0]};
      end
      emb_pkg::EMB_ACC_BIT: begin
        if (acc_addr[7]) begin
          tgt      = emb_pkg::EMB_TGT_IO;
          tgt_addr = {8'h00, acc_addr[7:3], 3'b000};
        end else begin
          tgt      = emb_pkg::EMB_TGT_RAM;
          tgt_addr = {8'h00, bit_byte};
        end
      end
      default: begin
        tgt = emb_pkg::EMB_TGT_NONE;
      end
    endcase
  end
endmodule
`default_nettype wire

// ---- rtl/emb_ext_mem_bus.sv ----
`default_nettype none
module emb_ext_mem_bus #(
  parameter int unsigned ADDR_W = 16
) (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               reset,
  // mode and configuration
  input  wire logic               fast_mode,
  input  wire logic               latch_strobe_disable,
  input  wire logic [7:0]         program_status_word,
  input  wire logic [7:0]         aux_control_reg,
  input  wire logic [7:0]         memory_control_reg,
  input  wire logic               signature_enable,
  input  wire logic               security_active,
  input  wire logic               programmer_access,
  // core request
  input  wire logic               req_valid,
  input  wire logic [2:0]         req_kind,
  input  wire logic [ADDR_W-1:0]  req_addr,
  input  wire logic [7:0]         req_reg_num,
  input  wire logic               req_write,
  input  wire logic [7:0]         req_wdata,
  output logic                    req_ready,
  // core answer
  output logic                    rsp_valid,
  output logic [7:0]              rsp_rdata,
  output logic [2:0]              rsp_target,
  output logic [15:0]             rsp_addr,
  output logic                    rsp_write_ok,
  // external bus pins
  output logic [7:0]              upper_addr_port,
  output logic [7:0]              low_addr_data_port_o,
  output logic                    low_addr_data_port_oe,
  input  wire logic [7:0]         low_addr_data_port_i,
  output logic                    addr_latch_strobe,
  output logic                    prog_fetch_strobe_n,
  output logic                    ext_read_strobe_n,
  output logic                    ext_write_strobe_n
);
  typedef struct packed {
    emb_pkg::emb_state_t st;
    logic [1:0]          phase;     // cleared at slot start, never advanced
    logic [1:0]          wait_cnt;  // fast mode stretch
    logic                is_fetch;
    logic                is_write;
    logic [15:0]         addr;
    logic [7:0]          wdata;
    logic [7:0]          upper;
    logic [7:0]          low_o;
    logic                low_oe;
    logic                ale;
    logic                ftch_n;
    logic                rd_n;
    logic                wr_n;
    logic                rsp_v;
    logic [7:0]          rdata;
    logic [2:0]          tgt;
    logic [15:0]         taddr;
    logic                tok;
  } emb_bus_state_t;

  emb_bus_state_t s_reg;
  emb_bus_state_t s_next;
  logic [2:0]     dec_tgt;
  logic [15:0]    dec_addr;
  logic           dec_wok;
  logic           stretch_done;

  // address space decode
  emb_space_decode u_decode (
    .acc_kind           (req_kind),
    .acc_addr           (req_addr[15:0]),
    .acc_reg_num        (req_reg_num),
    .acc_write          (req_write),
    .signature_enable   (signature_enable),
    .in_app_prog_select (memory_control_reg[emb_pkg::MEMCTL_PROG_SEL]),
    .force_external_ram (aux_control_reg[emb_pkg::AUX_FORCE_EXT]),
    .flash_data_enable  (memory_control_reg[emb_pkg::MEMCTL_FLASH_EN]),
    .security_active    (security_active),
    .programmer_access  (programmer_access),
    .bank_select_lo     (program_status_word[emb_pkg::STATUS_BANK_LO]),
    .bank_select_hi     (program_status_word[emb_pkg::STATUS_BANK_HI]),
    .tgt                (dec_tgt),
    .tgt_addr           (dec_addr),
    .tgt_write_ok       (dec_wok)
  );

  // fast mode holds each bus clock for three system clocks
  assign stretch_done = !fast_mode ||
                        (s_reg.wait_cnt == 2'(emb_pkg::FAST_STRETCH - 1));

  // sequencer: one slot = addr (latch high), strobe, data clocks
  always_comb begin
    s_next       = s_reg;
    s_next.rsp_v = 1'b0;
    req_ready    = (s_reg.st == emb_pkg::EMB_ST_IDLE);
    if (s_reg.st != emb_pkg::EMB_ST_IDLE) begin
      s_next.wait_cnt = stretch_done ? 2'd0 : s_reg.wait_cnt + 2'd1;
    end
    case (s_reg.st)
      emb_pkg::EMB_ST_IDLE: begin
        s_next.ale    = 1'b0;
        s_next.ftch_n = 1'b1;
        s_next.rd_n   = 1'b1;
        s_next.wr_n   = 1'b1;
        s_next.low_oe = 1'b0;
        if (req_valid) begin
          s_next.tgt   = dec_tgt;
          s_next.taddr = dec_addr;
          s_next.tok   = dec_wok;
          if (dec_tgt == 3'(emb_pkg::EMB_TGT_EXT)) begin
            s_next.st       = emb_pkg::EMB_ST_ADDR;
            s_next.phase    = 2'd0;
            s_next.wait_cnt = 2'd0;
            s_next.is_fetch = (req_kind == 3'(emb_pkg::EMB_ACC_FETCH)) ||
                              (req_kind == 3'(emb_pkg::EMB_ACC_CTAB));
            s_next.is_write = req_write;
            s_next.addr     = dec_addr;
            s_next.wdata    = req_wdata;
            s_next.upper    = dec_addr[15:8];
            s_next.low_o    = dec_addr[7:0];
            s_next.low_oe   = 1'b1;
            s_next.ale      = !latch_strobe_disable;
          end else begin
            // internal target: answer at once, pins stay quiet
            s_next.rsp_v = 1'b1;
            s_next.rdata = 8'h00;
          end
        end
      end
      emb_pkg::EMB_ST_ADDR: begin
        if (stretch_done) begin
          // latch falls with address stable; strobe falls for fetch
          s_next.st  = emb_pkg::EMB_ST_STROBE;
          s_next.ale = 1'b0;
          if (s_reg.is_fetch) begin
            s_next.ftch_n = 1'b0;
            s_next.low_oe = 1'b0;
          end else if (s_reg.is_write) begin
            s_next.wr_n  = 1'b0;
            s_next.low_o = s_reg.wdata;
          end else begin
            s_next.rd_n   = 1'b0;
            s_next.low_oe = 1'b0;
          end
        end
      end
      emb_pkg::EMB_ST_STROBE: begin
        if (stretch_done) begin
          s_next.st = emb_pkg::EMB_ST_DATA;
        end
      end
      emb_pkg::EMB_ST_DATA: begin
        if (stretch_done) begin
          // sample in the last clock before the strobe rises
          s_next.st     = emb_pkg::EMB_ST_IDLE;
          s_next.rdata  = s_reg.is_write ? 8'h00 : low_addr_data_port_i;
          s_next.rsp_v  = 1'b1;
          s_next.ftch_n = 1'b1;
          s_next.rd_n   = 1'b1;
          s_next.wr_n   = 1'b1;
          s_next.low_oe = 1'b0;
        end
      end
      default: begin
        s_next.st = emb_pkg::EMB_ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_reg        <= '0;
      s_reg.st     <= emb_pkg::EMB_ST_IDLE;
      s_reg.upper  <= emb_pkg::PORT_RESET;
      s_reg.low_o  <= emb_pkg::PORT_RESET;
      s_reg.ftch_n <= 1'b1;
      s_reg.rd_n   <= 1'b1;
      s_reg.wr_n   <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs from flip-flops
  assign upper_addr_port       = s_reg.upper;
  assign low_addr_data_port_o  = s_reg.low_o;
  assign low_addr_data_port_oe = s_reg.low_oe;
  assign addr_latch_strobe     = s_reg.ale;
  assign prog_fetch_strobe_n   = s_reg.ftch_n;
  assign ext_read_strobe_n     = s_reg.rd_n;
  assign ext_write_strobe_n    = s_reg.wr_n;
  assign rsp_valid             = s_reg.rsp_v;
  assign rsp_rdata             = s_reg.rdata;
  assign rsp_target            = s_reg.tgt;
  assign rsp_addr              = s_reg.taddr;
  assign rsp_write_ok          = s_reg.tok;
endmodule
`default_nettype wire

// ---- dv/emb_ext_mem_bus_monitor.sv ----
`default_nettype none
module emb_ext_mem_bus_monitor #(
  parameter int unsigned ADDR_W = 16
) (
  // clock, reset and levels
  input wire logic              clk_sys,
  input wire logic              reset,
  input wire logic              fast_mode,
  input wire logic              latch_strobe_disable,
  input wire logic              signature_enable,
  // core side
  input wire logic              req_valid,
  input wire logic              req_ready,
  input wire logic              req_write,
  input wire logic [2:0]        req_kind,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [7:0]        req_wdata,
  input wire logic              rsp_valid,
  input wire logic [2:0]        rsp_target,
  input wire logic [7:0]        rsp_rdata,
  // bus pins
  input wire logic [7:0]        upper_addr_port,
  input wire logic [7:0]        low_addr_data_port_o,
  input wire logic [7:0]        low_addr_data_port_i,
  input wire logic              low_addr_data_port_oe,
  input wire logic              addr_latch_strobe,
  input wire logic              prog_fetch_strobe_n,
  input wire logic              ext_read_strobe_n,
  input wire logic              ext_write_strobe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // request take, bus idle and external fetch terms
  wire logic take  = req_valid && req_ready;
  wire logic quiet = prog_fetch_strobe_n && ext_read_strobe_n && ext_write_strobe_n;
  wire logic xf    = take && req_kind == emb_pkg::EMB_ACC_FETCH &&
                     req_addr > emb_pkg::CODE_INT_TOP;
  logic [15:0] addr_reg;
  logic [7:0]  wdata_reg;
  // remember address and data of the access in flight
  always_ff @(posedge clk_sys) begin
    if (take) begin
      addr_reg  <= 16'(req_addr);
      wdata_reg <= req_wdata;
    end
  end
  // answer spacing of one fetch slot, plain and stretched
  sequence s_compat_wait; !rsp_valid [*2] ##[1:2] rsp_valid; endsequence
  sequence s_fast_wait; !rsp_valid [*8] ##[1:2] rsp_valid; endsequence
  a_reset_quiet: assert property ($fell(reset) |-> quiet && !addr_latch_strobe && !rsp_valid
    && !low_addr_data_port_oe && upper_addr_port == 8'hff) else $error("bus not idle after reset");
  a_compat_fetch: assert property (xf && !fast_mode |=> s_compat_wait)
    else $error("compat fetch answer off");
  a_fast_fetch: assert property (xf && fast_mode |=> s_fast_wait)
    else $error("fast fetch answer off");
  a_internal_quiet: assert property (take && req_kind[2] |=> rsp_valid && quiet)
    else $error("internal access touched bus");
  a_low_code: assert property (take && req_kind == emb_pkg::EMB_ACC_FETCH &&
    req_addr <= emb_pkg::CODE_INT_TOP |=> rsp_valid && quiet &&
    rsp_target == emb_pkg::EMB_TGT_CODE) else $error("low fetch went out");
  a_sig_table: assert property (take && signature_enable &&
    req_kind == emb_pkg::EMB_ACC_CTAB |=> rsp_valid && quiet &&
    rsp_target != emb_pkg::EMB_TGT_CODE) else $error("table read wrong");
  a_latch_addr: assert property ($fell(addr_latch_strobe) |->
    {$past(upper_addr_port), $past(low_addr_data_port_o)} == addr_reg) else $error("bad latch addr");
  a_upper_steady: assert property (!quiet |-> upper_addr_port == addr_reg[15:8])
    else $error("upper byte moved");
  a_ale_width: assert property ($rose(addr_latch_strobe) && !fast_mode |=> !addr_latch_strobe)
    else $error("latch pulse width");
  a_fetch_duty: assert property ($fell(prog_fetch_strobe_n) && !fast_mode |->
    !low_addr_data_port_oe ##1 !prog_fetch_strobe_n ##1 prog_fetch_strobe_n)
    else $error("fetch duty");
  a_fetch_sample: assert property ($rose(prog_fetch_strobe_n) |->
    rsp_rdata == $past(low_addr_data_port_i)) else $error("fetch byte not sampled");
  a_write_data: assert property (!ext_write_strobe_n |-> low_addr_data_port_oe &&
    low_addr_data_port_o == wdata_reg) else $error("write data not driven");
  a_latch_off: assert property (latch_strobe_disable && $past(latch_strobe_disable)
    |-> !addr_latch_strobe) else $error("latch strobe not suppressed");
  a_busy_refuse: assert property (!quiet |-> !req_ready)
    else $error("request taken mid access");
endmodule
bind emb_ext_mem_bus emb_ext_mem_bus_monitor #(.ADDR_W(ADDR_W)) i_mon (
  .clk_sys               (clk_sys),
  .reset                 (reset),
  .fast_mode             (fast_mode),
  .latch_strobe_disable  (latch_strobe_disable),
  .signature_enable      (signature_enable),
  .req_valid             (req_valid),
  .req_ready             (req_ready),
  .req_write             (req_write),
  .req_kind              (req_kind),
  .req_addr              (req_addr),
  .req_wdata             (req_wdata),
  .rsp_valid             (rsp_valid),
  .rsp_target            (rsp_target),
  .rsp_rdata             (rsp_rdata),
  .upper_addr_port       (upper_addr_port),
  .low_addr_data_port_o  (low_addr_data_port_o),
  .low_addr_data_port_i  (low_addr_data_port_i),
  .low_addr_data_port_oe (low_addr_data_port_oe),
  .addr_latch_strobe     (addr_latch_strobe),
  .prog_fetch_strobe_n   (prog_fetch_strobe_n),
  .ext_read_strobe_n     (ext_read_strobe_n),
  .ext_write_strobe_n    (ext_write_strobe_n)
);
`default_nettype wire

// ---- dv/emb_mem_model.sv ----
`default_nettype none
module emb_mem_model (
  // bus pins from the device
  input  wire logic       clk_sys,
  input  wire logic [7:0] upper_addr_port,
  input  wire logic [7:0] port_o,
  input  wire logic       port_oe,
  input  wire logic       ale,
  input  wire logic       fetch_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  // resolved low port and last written byte
  output logic      [7:0] port_i,
  output logic      [7:0] last_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] low_reg  = 8'h00;
  logic [7:0] prev_reg = 8'h00;
  // latch low address while the strobe is high, take written bytes
  always @(posedge clk_sys) begin
    if (ale) low_reg <= port_o;
    if (!wr_n) last_wdata <= port_o;
    prev_reg <= port_i;
  end
  // echo the driven byte while driving, answer under a fetch or read strobe, otherwise a level that changes each cycle
  assign port_i = port_oe ? port_o : (!fetch_n || !rd_n) ? low_reg ^ upper_addr_port ^ 8'h5a
                : ~prev_reg;
endmodule
`default_nettype wire

// ---- dv/emb_ext_mem_bus_tb.sv ----
`default_nettype none
module emb_ext_mem_bus_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // clock, reset and configuration
  logic clk_sys = 1'b0, reset = 1'b1, fast_mode = 1'b0, latch_strobe_disable = 1'b0;
  logic signature_enable = 1'b0, security_active = 1'b0, programmer_access = 1'b0;
  logic [7:0] program_status_word = 8'h00, aux_control_reg = 8'h00, memory_control_reg = 8'h00;
  // request and answer
  logic req_valid = 1'b0, req_write = 1'b0, req_ready, rsp_valid, rsp_write_ok;
  logic [2:0] req_kind = 3'h0, rsp_target;
  logic [15:0] req_addr = 16'h0000, rsp_addr;
  logic [7:0] req_reg_num = 8'h00, req_wdata = 8'h00, rsp_rdata, wd;
  // external bus
  logic [7:0] upper_addr_port, low_addr_data_port_o, low_addr_data_port_i, last_wdata;
  logic low_addr_data_port_oe, addr_latch_strobe, prog_fetch_strobe_n;
  logic ext_read_strobe_n, ext_write_strobe_n;
  int failures = 0, total_checks = 0, seed = 32'h1706999f;
  logic [28:0] eq[$];
  logic [28:0] ex;
  logic [2:0] n;
  emb_ext_mem_bus #(.ADDR_W(16)) i_dut (
    .clk_sys               (clk_sys),
    .reset                 (reset),
    .fast_mode             (fast_mode),
    .latch_strobe_disable  (latch_strobe_disable),
    .program_status_word   (program_status_word),
    .aux_control_reg       (aux_control_reg),
    .memory_control_reg    (memory_control_reg),
    .signature_enable      (signature_enable),
    .security_active       (security_active),
    .programmer_access     (programmer_access),
    .req_valid             (req_valid),
    .req_kind              (req_kind),
    .req_addr              (req_addr),
    .req_reg_num           (req_reg_num),
    .req_write             (req_write),
    .req_wdata             (req_wdata),
    .req_ready             (req_ready),
    .rsp_valid             (rsp_valid),
    .rsp_rdata             (rsp_rdata),
    .rsp_target            (rsp_target),
    .rsp_addr              (rsp_addr),
    .rsp_write_ok          (rsp_write_ok),
    .upper_addr_port       (upper_addr_port),
    .low_addr_data_port_o  (low_addr_data_port_o),
    .low_addr_data_port_oe (low_addr_data_port_oe),
    .low_addr_data_port_i  (low_addr_data_port_i),
    .addr_latch_strobe     (addr_latch_strobe),
    .prog_fetch_strobe_n   (prog_fetch_strobe_n),
    .ext_read_strobe_n     (ext_read_strobe_n),
    .ext_write_strobe_n    (ext_write_strobe_n)
  );
  emb_mem_model i_mem (.clk_sys(clk_sys), .upper_addr_port(upper_addr_port),
    .port_o(low_addr_data_port_o), .port_oe(low_addr_data_port_oe), .ale(addr_latch_strobe),
    .fetch_n(prog_fetch_strobe_n), .rd_n(ext_read_strobe_n), .wr_n(ext_write_strobe_n),
    .port_i(low_addr_data_port_i), .last_wdata(last_wdata));
  always #10 clk_sys = ~clk_sys;
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one access: c = prog, security, fast, sig, prog select, flash enable, force external
  task automatic acc(input logic [2:0] k, input logic [15:0] a, input logic [6:0] c,
                     input logic w, input logic [2:0] t, input logic [15:0] ea);
    {programmer_access, security_active, fast_mode, signature_enable} <= c[6:3];
    memory_control_reg <= {c[2], 3'h0, c[1], 3'h0};
    aux_control_reg <= {6'h00, c[0], 1'b0};
    {req_kind, req_addr, req_write, req_valid} <= {k, a, w, 1'b1};
    eq.push_back({w, t, ea, (t == 3'h0 && !w) ? a[7:0] ^ a[15:8] ^ 8'h5a : 8'h00,
                  !(c[5] && !c[6] && w && t == 3'h2)});
    @(posedge clk_sys);
    req_valid <= 1'b0;
    repeat (16) begin
      @(negedge clk_sys);
      if (rsp_valid === 1'b1) break;
    end
    if (rsp_valid !== 1'b1) failures++;
    if (w && t == 3'h0) cmp(16'(last_wdata), 16'(wd));
    @(posedge clk_sys);
    $display("test kind %h addr %h done", k, a);
  endtask
  // compare each answer with the oldest note
  always @(negedge clk_sys) begin
    if (rsp_valid === 1'b1) begin
      ex = eq.pop_front();
      cmp(16'(rsp_target), 16'(ex[27:25]));
      cmp(rsp_addr, ex[24:9]);
      cmp(16'(rsp_rdata), 16'(ex[8:1]));
      if (ex[28]) cmp(16'(rsp_write_ok), 16'(ex[0]));
    end
  end
  initial begin
    #200000;
    failures++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    acc(3'h0, 16'h2345, 7'h00, 1'b0, 3'h0, 16'h2345);
    latch_strobe_disable <= 1'b1;
    acc(3'h0, 16'h2345, 7'h00, 1'b0, 3'h0, 16'h2345);
    latch_strobe_disable <= 1'b0;
    acc(3'h0, 16'h1fff, 7'h00, 1'b0, 3'h1, 16'h1fff);
    acc(3'h0, 16'hf0c3, 7'h10, 1'b0, 3'h0, 16'hf0c3);
    acc(3'h1, 16'h0150, 7'h08, 1'b0, 3'h2, 16'h0150);
    acc(3'h1, 16'h0040, 7'h08, 1'b0, 3'h2, 16'h0040);
    acc(3'h1, 16'h0150, 7'h00, 1'b0, 3'h1, 16'h0150);
    acc(3'h1, 16'h8000, 7'h00, 1'b0, 3'h0, 16'h8000);
    acc(3'h2, 16'h0033, 7'h0c, 1'b0, 3'h2, 16'h0133);
    acc(3'h2, 16'h00ff, 7'h02, 1'b0, 3'h5, 16'h00ff);
    acc(3'h2, 16'h0100, 7'h02, 1'b0, 3'h0, 16'h0100);
    acc(3'h2, 16'h0010, 7'h00, 1'b0, 3'h0, 16'h0010);
    acc(3'h3, 16'h0010, 7'h02, 1'b0, 3'h0, 16'h0010);
    acc(3'h2, 16'h0010, 7'h03, 1'b0, 3'h0, 16'h0010);
    wd = 8'($random(seed));
    req_wdata <= wd;
    acc(3'h2, 16'h4321, 7'h00, 1'b1, 3'h0, 16'h4321);
    for (int i = 0; i < 3; i++) begin
      acc(3'h2, 16'h0055, {i == 2, i != 0, 5'h0c}, 1'b1, 3'h2, 16'h0155);
    end
    acc(3'h4, 16'h0085, 7'h00, 1'b0, 3'h4, 16'h0085);
    acc(3'h4, 16'h0030, 7'h00, 1'b0, 3'h3, 16'h0030);
    acc(3'h5, 16'h0085, 7'h00, 1'b0, 3'h3, 16'h0085);
    for (int i = 0; i < 4; i++) begin
      n = 3'($random(seed));
      program_status_word <= {3'h0, 2'(i), 3'h0};
      req_reg_num <= {5'h00, n};
      acc(3'h6, 16'h0000, 7'h00, 1'b0, 3'h3, {11'h000, 2'(i), n});
    end
    acc(3'h7, 16'h0013, 7'h00, 1'b0, 3'h3, 16'h0022);
    acc(3'h7, 16'h007f, 7'h00, 1'b0, 3'h3, 16'h002f);
    finish_test();
  end
endmodule
`default_nettype wire
